/* src/fail_safe_supervisor.sv */
// Local design decisions: the APB slave port and the register addresses.
`timescale 1ns/1ns
module fail_safe_supervisor #(
  parameter int SETTLE_CYCLES = fail_safe_pkg::SETTLE_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic mainOscIn,
  input wire logic rcOscIn,
  input wire logic externalIrqZeroPin,
  input wire logic canReceivePin,
  output logic cpuReset,
  output logic clockSelRc,
  output logic oscEnable,
  output logic vectorValid,
  output logic [15:0] vectorAddr,
  output logic irq
);

  // pin synchronisers: main osc, rc osc, irq zero, can receive
  logic [3:0] pinRaw;
  logic [3:0] pinMeta_q;
  logic [3:0] pinSync_q;
  logic [3:0] pinPrev_q;
  assign pinRaw = {canReceivePin, externalIrqZeroPin, rcOscIn, mainOscIn};

  for (genvar i = 0; i < 4; i++) begin : gSync
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        pinMeta_q[i] <= 1'b1;
        pinSync_q[i] <= 1'b1;
        pinPrev_q[i] <= 1'b1;
      end else begin
        pinMeta_q[i] <= pinRaw[i];
        pinSync_q[i] <= pinMeta_q[i];
        pinPrev_q[i] <= pinSync_q[i];
      end
    end
  end

  logic mainEdge;
  logic rcEdge;
  logic wakePinLow;
  assign mainEdge = pinSync_q[0] && !pinPrev_q[0];
  assign rcEdge = pinSync_q[1] && !pinPrev_q[1];
  assign wakePinLow = !pinSync_q[2] || !pinSync_q[3];

  // apb slave: one wait-free access phase, answer prepared in setup
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic addrHit;
  logic [31:0] readWord;
  logic setup;
  logic wrEn;
  logic ctrlWr;
  fail_safe_pkg::ctrl_t wrCtrl;

  fail_safe_pkg::ctrl_t ctrl_q;
  logic [fail_safe_pkg::RELOAD_W-1:0] reload_q;
  logic [fail_safe_pkg::IRQ_W-1:0] irqStat_q;
  logic [fail_safe_pkg::IRQ_W-1:0] irqMask_q;
  logic [fail_safe_pkg::WDT_W-1:0] count_q;
  logic running_q;
  logic cause_q;
  fail_safe_pkg::osc_state_t oscState_q;
  fail_safe_pkg::status_t statusWord;

  assign setup = psel && !penable;
  assign wrEn = psel && penable && pready_q && pwrite && !pslverr_q;
  assign wrCtrl = fail_safe_pkg::ctrl_t'(pwdata[fail_safe_pkg::CTRL_W-1:0]);
  assign ctrlWr = wrEn && (paddr == fail_safe_pkg::OFS_CTRL);

  assign statusWord = '{idleMode: ctrl_q.idleMode,
                        inPowerDown: oscState_q == fail_safe_pkg::OSC_PDOWN,
                        clockOnRc: clockSelRc,
                        running: running_q,
                        watchdogResetCauseFlag: cause_q};

  always_comb begin
    addrHit = 1'b1;
    readWord = 32'h0000_0000;
    unique case (paddr)
      fail_safe_pkg::OFS_CTRL: begin
        readWord[fail_safe_pkg::CTRL_W-1:0] =
          {ctrl_q.powerDown, ctrl_q.idleMode, ctrl_q.slowRate, running_q, 1'b0};
      end
      fail_safe_pkg::OFS_RELOAD: readWord[fail_safe_pkg::RELOAD_W-1:0] = reload_q;
      fail_safe_pkg::OFS_STATUS: readWord[fail_safe_pkg::STAT_W-1:0] = statusWord;
      fail_safe_pkg::OFS_IRQ_STAT: readWord[fail_safe_pkg::IRQ_W-1:0] = irqStat_q;
      fail_safe_pkg::OFS_IRQ_MASK: readWord[fail_safe_pkg::IRQ_W-1:0] = irqMask_q;
      fail_safe_pkg::OFS_COUNT: readWord[fail_safe_pkg::WDT_W-1:0] = count_q;
      default: addrHit = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= setup;
      pslverr_q <= setup && !addrHit;
      if (setup) begin
        prdata_q <= addrHit ? readWord : 32'h0000_0000;
      end
    end
  end

  // refresh pairing: the write right after a refresh-bit write
  logic armed_q;
  logic refreshNow;
  assign refreshNow = ctrlWr && wrCtrl.watchdogStartBit && armed_q && running_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      armed_q <= 1'b0;
    end else if (wrEn) begin
      // any other write without pslverr in between breaks the pair
      armed_q <= ctrlWr && wrCtrl.watchdogRefreshBit;
    end
  end

  // prescaler chain, frozen along with the counter
  logic wdtRun;
  logic div2_q;
  logic [2:0] mach_q;
  logic [3:0] pre16_q;
  logic machTick;
  logic wdtTick;
  logic overflowEv;
  // idle and power-down halt the count
  assign wdtRun = running_q && !ctrl_q.idleMode && oscState_q == fail_safe_pkg::OSC_RUN;
  assign machTick = wdtRun && div2_q && (mach_q == fail_safe_pkg::MACH_LAST);
  assign wdtTick = ctrl_q.slowRate ? machTick && (pre16_q == fail_safe_pkg::PRE16_LAST)
                                   : machTick;
  assign overflowEv = wdtTick && !refreshNow && (count_q == fail_safe_pkg::WDT_MAX);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div2_q <= 1'b0;
      mach_q <= 3'h0;
      pre16_q <= 4'h0;
    end else if (wdtRun) begin
      div2_q <= !div2_q;
      if (div2_q) begin
        mach_q <= (mach_q == fail_safe_pkg::MACH_LAST) ? 3'h0 : 3'(mach_q + 3'h1);
      end
      if (machTick) begin
        pre16_q <= 4'(pre16_q + 4'h1);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= '0;
      running_q <= 1'b0;
    end else if (refreshNow) begin
      // reload into the upper bits; low bits restart at zero
      count_q <= {reload_q, {fail_safe_pkg::LOW_W{1'b0}}};
    end else if (overflowEv) begin
      // overflow ends this run through the internal reset
      count_q <= '0;
      running_q <= 1'b0;
    end else begin
      if (wdtTick) begin
        count_q <= fail_safe_pkg::WDT_W'(count_q + 15'h0001);
      end
      // start only; no path clears running apart from overflow
      if (ctrlWr && wrCtrl.watchdogStartBit) begin
        running_q <= 1'b1;
      end
    end
  end

  // cause flag: only rst_n clears it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cause_q <= 1'b0;
    end else if (overflowEv) begin
      cause_q <= 1'b1;
    end
  end

  // oscillator comparison over a window of rc edges
  logic [3:0] rcCnt_q;
  logic [3:0] mainCnt_q;
  logic windowDone;
  logic mainSlow;
  assign windowDone = rcEdge && (rcCnt_q == 4'(fail_safe_pkg::RC_WINDOW - 4'h1));
  assign mainSlow = (mainCnt_q + {3'h0, mainEdge}) < {1'b0, fail_safe_pkg::RC_WINDOW};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rcCnt_q <= 4'h0;
      mainCnt_q <= 4'h0;
    end else if (oscState_q == fail_safe_pkg::OSC_PDOWN || windowDone) begin
      rcCnt_q <= 4'h0;
      mainCnt_q <= 4'h0;
    end else begin
      if (rcEdge) begin
        rcCnt_q <= 4'(rcCnt_q + 4'h1);
      end
      // saturate so a fast main clock never wraps to look slow
      if (mainEdge && mainCnt_q != 4'hF) begin
        mainCnt_q <= 4'(mainCnt_q + 4'h1);
      end
    end
  end

  logic [fail_safe_pkg::SETTLE_W-1:0] settleCnt_q;
  logic wakePending_q;
  logic settleDone;
  logic oscFailEv;
  logic pdownReq;
  assign settleDone = settleCnt_q == fail_safe_pkg::SETTLE_W'(SETTLE_CYCLES - 1);
  assign oscFailEv = oscState_q == fail_safe_pkg::OSC_RUN && windowDone && mainSlow;
  assign pdownReq = ctrlWr && wrCtrl.powerDown;

  // reset value is the fail state, so power-on runs the monitor too
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      oscState_q <= fail_safe_pkg::OSC_FAIL;
      settleCnt_q <= '0;
      wakePending_q <= 1'b0;
    end else begin
      settleCnt_q <= '0;
      unique case (oscState_q)
        fail_safe_pkg::OSC_FAIL: begin
          wakePending_q <= 1'b0;
          if (windowDone && !mainSlow) begin
            oscState_q <= fail_safe_pkg::OSC_SETTLE;
          end
        end
        fail_safe_pkg::OSC_SETTLE: begin
          settleCnt_q <= fail_safe_pkg::SETTLE_W'(settleCnt_q + 16'h0001);
          if (windowDone && mainSlow) begin
            // failure during settling falls back to reset
            oscState_q <= fail_safe_pkg::OSC_FAIL;
          end else if (settleDone) begin
            oscState_q <= fail_safe_pkg::OSC_RUN;
            wakePending_q <= 1'b0;
          end
        end
        fail_safe_pkg::OSC_RUN: begin
          if (oscFailEv) begin
            oscState_q <= fail_safe_pkg::OSC_FAIL;
          end else if (pdownReq) begin
            oscState_q <= fail_safe_pkg::OSC_PDOWN;
          end
        end
        fail_safe_pkg::OSC_PDOWN: begin
          // low level on either wake pin
          if (wakePinLow) begin
            oscState_q <= fail_safe_pkg::OSC_WAKE;
            wakePending_q <= 1'b1;
          end
        end
        fail_safe_pkg::OSC_WAKE: begin
          // wait for main to keep up with rc before the delay
          if (windowDone && !mainSlow) begin
            oscState_q <= fail_safe_pkg::OSC_SETTLE;
          end
        end
      endcase
    end
  end

  // control register: rate, idle, power-down
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= fail_safe_pkg::CTRL_RESET;
      reload_q <= fail_safe_pkg::RELOAD_RESET;
      irqMask_q <= fail_safe_pkg::IRQ_MASK_RESET;
    end else begin
      if (ctrlWr) begin
        ctrl_q.slowRate <= wrCtrl.slowRate;
        ctrl_q.idleMode <= wrCtrl.idleMode;
      end
      // power-down bit tracks the supervisor state
      ctrl_q.powerDown <= oscState_q == fail_safe_pkg::OSC_PDOWN || pdownReq;
      if (oscState_q == fail_safe_pkg::OSC_FAIL || overflowEv) begin
        ctrl_q.idleMode <= 1'b0;
      end
      if (wrEn && paddr == fail_safe_pkg::OFS_RELOAD) begin
        reload_q <= pwdata[fail_safe_pkg::RELOAD_W-1:0];
      end
      if (wrEn && paddr == fail_safe_pkg::OFS_IRQ_MASK) begin
        irqMask_q <= pwdata[fail_safe_pkg::IRQ_W-1:0];
      end
    end
  end

  // sticky events, write one to clear; a new event beats the clear
  logic [fail_safe_pkg::IRQ_W-1:0] irqSet;
  logic [fail_safe_pkg::IRQ_W-1:0] irqClr;
  assign irqSet = {oscFailEv, overflowEv};
  assign irqClr = (wrEn && paddr == fail_safe_pkg::OFS_IRQ_STAT) ?
                  pwdata[fail_safe_pkg::IRQ_W-1:0] : '0;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irqStat_q <= '0;
      irq <= 1'b0;
    end else begin
      irqStat_q <= (irqStat_q & ~irqClr) | irqSet;
      irq <= |(irqStat_q & irqMask_q);
    end
  end

  // reset hold after overflow and the registered pin outputs
  logic [fail_safe_pkg::HOLD_W-1:0] holdCnt_q;
  logic cpuReset_q;
  logic clockSelRc_q;
  logic oscEnable_q;
  logic vectorValid_q;
  logic [15:0] vectorAddr_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      holdCnt_q <= '0;
      cpuReset_q <= 1'b1;
      clockSelRc_q <= 1'b1;
      oscEnable_q <= 1'b1;
      vectorValid_q <= 1'b0;
      vectorAddr_q <= fail_safe_pkg::VEC_RESET;
    end else begin
      if (overflowEv) begin
        holdCnt_q <= fail_safe_pkg::RESET_HOLD;
      end else if (holdCnt_q != '0) begin
        holdCnt_q <= fail_safe_pkg::HOLD_W'(holdCnt_q - 5'h01);
      end
      // reset while held, failed or settling from fail
      cpuReset_q <= overflowEv || holdCnt_q > 5'h01 ||
                    oscState_q == fail_safe_pkg::OSC_FAIL ||
                    (oscState_q == fail_safe_pkg::OSC_SETTLE && !wakePending_q);
      // rc clocks the part until main is proven
      clockSelRc_q <= oscState_q == fail_safe_pkg::OSC_FAIL ||
                      oscState_q == fail_safe_pkg::OSC_WAKE;
      oscEnable_q <= !(oscState_q == fail_safe_pkg::OSC_PDOWN && !wakePinLow);
      vectorValid_q <= oscState_q == fail_safe_pkg::OSC_SETTLE && settleDone &&
                       !(windowDone && mainSlow);
      if (oscState_q == fail_safe_pkg::OSC_SETTLE && settleDone) begin
        // zero after reset, fixed wake vector after power-down
        vectorAddr_q <= wakePending_q ? fail_safe_pkg::VEC_WAKE : fail_safe_pkg::VEC_RESET;
      end
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign cpuReset = cpuReset_q;
  assign clockSelRc = clockSelRc_q;
  assign oscEnable = oscEnable_q;
  assign vectorValid = vectorValid_q;
  assign vectorAddr = vectorAddr_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_ovf_resets_cpu: assert property (overflowEv |=> cpuReset_q [*8])
    else $error("overflow did not hold cpu reset");
  chk_ovf_sets_cause: assert property (overflowEv |=> cause_q && !running_q)
    else $error("overflow did not mark reset cause");
  chk_refresh_loads: assert property (refreshNow |=>
    count_q == {$past(reload_q), 8'h00})
    else $error("refresh did not load reload value");
  chk_no_stop: assert property (running_q && !overflowEv |=> running_q)
    else $error("watchdog stopped without overflow");
  chk_halt_idle: assert property (!wdtRun && !refreshNow && !overflowEv |=>
    $stable(count_q))
    else $error("counter moved while halted");
  chk_single_write_no_refresh: assert property (ctrlWr && !armed_q |-> !refreshNow)
    else $error("refresh without preceding refresh write");
  chk_fail_holds_reset: assert property (oscState_q == fail_safe_pkg::OSC_FAIL |=>
    cpuReset_q && clockSelRc_q)
    else $error("oscillator failure not held in reset on rc");
  chk_pd_osc_off: assert property (oscState_q == fail_safe_pkg::OSC_PDOWN && !wakePinLow |=>
    !oscEnable_q)
    else $error("oscillators still enabled in power-down");
  chk_wake_vector: assert property (vectorValid_q && $past(wakePending_q) |->
    vectorAddr_q == fail_safe_pkg::VEC_WAKE && !cpuReset_q)
    else $error("wake-up did not use its vector");
  chk_rate_fast: assert property (wdtTick && !ctrl_q.slowRate |=>
    !wdtTick [*8])
    else $error("fast rate ticked too early");

  cov_overflow: cover property (overflowEv);
  cov_refresh: cover property (refreshNow);
  cov_wake: cover property (vectorValid_q && vectorAddr_q == fail_safe_pkg::VEC_WAKE);
  cov_osc_fail: cover property (oscFailEv);

endmodule

/* src/fail_safe_pkg.sv */
package fail_safe_pkg;

  // register byte offsets on the APB window
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_RELOAD = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h0C;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h10;
  localparam logic [7:0] OFS_COUNT = 8'h14;

  // control word, low five bits of OFS_CTRL
  localparam int CTRL_W = 5;
  typedef struct packed {
    logic powerDown;
    logic idleMode;
    logic slowRate;
    logic watchdogStartBit;
    logic watchdogRefreshBit;
  } ctrl_t;
  localparam ctrl_t CTRL_RESET = ctrl_t'(5'h00);

  // status word, low five bits of OFS_STATUS
  localparam int STAT_W = 5;
  typedef struct packed {
    logic idleMode;
    logic inPowerDown;
    logic clockOnRc;
    logic running;
    logic watchdogResetCauseFlag;
  } status_t;

  // sticky interrupt bits
  localparam int IRQ_W = 2;
  localparam int IRQ_WDT_OVF = 0;
  localparam int IRQ_OSC_FAIL = 1;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 2'h0;

  // watchdog counter geometry and prescalers
  localparam int WDT_W = 15;
  localparam int RELOAD_W = 7;
  localparam int LOW_W = WDT_W - RELOAD_W;
  localparam logic [RELOAD_W-1:0] RELOAD_RESET = 7'h00;
  localparam logic [WDT_W-1:0] WDT_MAX = 15'h7FFF;
  localparam int MACHINE_DIV = 6;
  localparam int PRE_DIV16 = 16;
  localparam logic [2:0] MACH_LAST = 3'(MACHINE_DIV - 1);
  localparam logic [3:0] PRE16_LAST = 4'(PRE_DIV16 - 1);

  // oscillator supervision timing
  localparam int CLK_HZ = 25_000_000;
  localparam int SETTLE_US = 1000;
  localparam int SETTLE_CYCLES = (CLK_HZ / 1_000_000) * SETTLE_US;
  localparam int SETTLE_W = 16;
  localparam logic [3:0] RC_WINDOW = 4'h8;
  localparam int HOLD_W = 5;
  localparam logic [HOLD_W-1:0] RESET_HOLD = 5'h10;

  // fetch addresses presented on release
  localparam logic [15:0] VEC_RESET = 16'h0000;
  localparam logic [15:0] VEC_WAKE = 16'h007B;

  typedef enum logic [4:0] {
    OSC_FAIL = 5'b00001,
    OSC_SETTLE = 5'b00010,
    OSC_RUN = 5'b00100,
    OSC_PDOWN = 5'b01000,
    OSC_WAKE = 5'b10000
  } osc_state_t;

endpackage

/* dv/test_fail_safe_supervisor.sv */
`timescale 1ns/1ns
module test_fail_safe_supervisor;
  localparam int SETTLE_SIM = 20;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic mainOscIn = 1'b0;
  logic rcOscIn = 1'b0;
  logic externalIrqZeroPin = 1'b1;
  logic canReceivePin = 1'b1;
  logic cpuReset;
  logic clockSelRc;
  logic oscEnable;
  logic vectorValid;
  logic [15:0] vectorAddr;
  logic irq;
  logic mainOn = 1'b1;
  logic [2:0] oscDiv = 3'h0;
  logic [31:0] lastData;
  logic lastErr;
  logic [31:0] firstCount;
  int failures = 0;
  int checkCount = 0;

  fail_safe_supervisor #(.SETTLE_CYCLES(SETTLE_SIM)) i_dut (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mainOscIn(mainOscIn), .rcOscIn(rcOscIn), .externalIrqZeroPin(externalIrqZeroPin),
    .canReceivePin(canReceivePin), .cpuReset(cpuReset), .clockSelRc(clockSelRc),
    .oscEnable(oscEnable), .vectorValid(vectorValid), .vectorAddr(vectorAddr), .irq(irq)
  );

  always #20 clk = ~clk;

  // far-side oscillators: main at clk/2, rc at clk/16, both frozen while disabled
  always @(posedge clk) begin
    oscDiv <= oscDiv + 3'h1;
    if (oscEnable === 1'b1) begin
      if (mainOn) begin
        mainOscIn <= ~mainOscIn;
      end
      if (oscDiv == 3'h7) begin
        rcOscIn <= ~rcOscIn;
      end
    end
  end

  task automatic checkWord(input string what, input logic [31:0] exp, input logic [31:0] got);
    checkCount++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic checkBit(input string what, input logic exp, input logic got);
    checkCount++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s: expected %b, seen %b", what, exp, got);
    end
  endtask

  task automatic apbCycle(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    lastData = prdata;
    lastErr = pslverr;
    if (n >= 50) failures++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic apbWrite(input logic [7:0] a, input logic [31:0] d);
    apbCycle(1'b1, a, d);
  endtask

  task automatic apbRead(input logic [7:0] a);
    apbCycle(1'b0, a, 32'h0);
  endtask

  task automatic refresh();
    apbWrite(fail_safe_pkg::OFS_CTRL, 32'h00000001);
    apbWrite(fail_safe_pkg::OFS_CTRL, 32'h00000002);
  endtask

  // waits for the fetch pulse; cpuReset must be low right after it
  task automatic waitVector(input logic [15:0] addr, input logic rstAtVec);
    int n;
    for (n = 0; n < 3000; n++) begin
      @(negedge clk);
      if (vectorValid === 1'b1) break;
    end
    checkBit("vector pulse", 1'b1, vectorValid);
    checkWord("vector address", 32'(addr), 32'(vectorAddr));
    checkBit("reset at vector", rstAtVec, cpuReset);
    @(negedge clk);
    checkBit("reset after vector", 1'b0, cpuReset);
  endtask

  // two COUNT reads whose sample points are exactly span cycles apart
  task automatic countStep(input int span, input logic [31:0] exp);
    apbRead(fail_safe_pkg::OFS_COUNT);
    firstCount = lastData;
    repeat (span - 3) @(posedge clk);
    apbRead(fail_safe_pkg::OFS_COUNT);
    checkWord("count advance", exp, lastData - firstCount);
  endtask

  task automatic endTest(input string name);
    $display("test %s finished, %0d mismatches so far", name, failures);
  endtask

  task automatic complete_run();
    $display("comparisons %0d, mismatches %0d", checkCount, failures);
    if (failures == 0 && checkCount > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge clk);
    failures++;
    complete_run();
  end

  initial begin
    int n;
    repeat (12) @(posedge clk);
    checkBit("reset during rst_n", 1'b1, cpuReset); // power-on
    checkBit("rc clock during rst_n", 1'b1, clockSelRc); // power-on
    rst_n <= 1'b1;
    waitVector(16'h0000, 1'b1); // fetch zero
    checkBit("clock back on main", 1'b0, clockSelRc); // clock select
    apbRead(fail_safe_pkg::OFS_STATUS);
    checkWord("status after power-on", 32'h0, lastData); // external cause
    apbRead(fail_safe_pkg::OFS_IRQ_MASK);
    checkWord("mask reset", 32'h0, lastData);
    apbRead(8'h18);
    checkBit("unmapped error", 1'b1, lastErr);
    checkWord("unmapped data", 32'h0, lastData);
    endTest("power_on");

    apbWrite(fail_safe_pkg::OFS_RELOAD, 32'hFFFFFFFF);
    apbRead(fail_safe_pkg::OFS_RELOAD);
    checkWord("reload width", 32'h0000007F, lastData); // seven bits
    apbWrite(fail_safe_pkg::OFS_CTRL, 32'h00000002);
    apbRead(fail_safe_pkg::OFS_STATUS);
    checkBit("running after start", 1'b1, lastData[1]); // start
    refresh();
    apbRead(fail_safe_pkg::OFS_COUNT);
    checkWord("count upper after refresh", 32'h7F, 32'(lastData[14:8])); // reload
    apbWrite(fail_safe_pkg::OFS_RELOAD, 32'h00000010);
    apbWrite(fail_safe_pkg::OFS_CTRL, 32'h00000001);
    apbWrite(fail_safe_pkg::OFS_RELOAD, 32'h00000010);
    apbWrite(fail_safe_pkg::OFS_CTRL, 32'h00000002);
    apbRead(fail_safe_pkg::OFS_COUNT);
    checkWord("count after broken sequence", 32'h7F, 32'(lastData[14:8])); // pattern
    endTest("refresh");

    apbWrite(fail_safe_pkg::OFS_RELOAD, 32'h0000007F);
    refresh();
    countStep(240, 32'd20); // divide by 12
    refresh();
    // refresh writes clear the rate bit, so select the slow rate afterwards
    apbWrite(fail_safe_pkg::OFS_CTRL, 32'h00000004);
    countStep(384, 32'd2); // divide by 192
    apbWrite(fail_safe_pkg::OFS_CTRL, 32'h00000008);
    countStep(240, 32'd0); // idle hold
    apbWrite(fail_safe_pkg::OFS_CTRL, 32'h00000000);
    apbRead(fail_safe_pkg::OFS_STATUS);
    checkBit("running survives stop attempt", 1'b1, lastData[1]); // no stop
    endTest("rate_idle");

    refresh();
    for (n = 0; n < 4000; n++) begin
      @(negedge clk);
      if (cpuReset === 1'b1) break;
    end
    for (n = 0; n < 40; n++) begin
      @(negedge clk);
      if (cpuReset !== 1'b1) break;
    end
    // the first high cycle was seen by the loop above
    checkWord("overflow reset length", 32'(fail_safe_pkg::RESET_HOLD), 32'(n + 1)); // overflow
    apbRead(fail_safe_pkg::OFS_STATUS);
    checkBit("watchdog cause", 1'b1, lastData[0]); // cause flag
    checkBit("running cleared", 1'b0, lastData[1]); // overflow
    apbRead(fail_safe_pkg::OFS_IRQ_STAT);
    checkWord("overflow event", 32'h1, lastData); // overflow
    checkBit("irq masked", 1'b0, irq);
    apbWrite(fail_safe_pkg::OFS_IRQ_MASK, 32'h00000001);
    repeat (2) @(negedge clk);
    checkBit("irq unmasked", 1'b1, irq);
    apbWrite(fail_safe_pkg::OFS_IRQ_STAT, 32'h00000001);
    repeat (2) @(negedge clk);
    checkBit("irq cleared", 1'b0, irq);
    endTest("overflow");

    mainOn <= 1'b0;
    for (n = 0; n < 600; n++) begin
      @(negedge clk);
      if (cpuReset === 1'b1) break;
    end
    checkBit("reset on slow main", 1'b1, cpuReset); // slow main
    checkBit("rc clock on slow main", 1'b1, clockSelRc); // slow main
    apbRead(fail_safe_pkg::OFS_IRQ_STAT);
    checkWord("osc fail event", 32'h2, lastData); // slow main
    apbWrite(fail_safe_pkg::OFS_IRQ_STAT, 32'h00000003);
    mainOn <= 1'b1;
    waitVector(16'h0000, 1'b1); // settle then fetch zero
    endTest("osc_fail");

    // wake-up through each pin in turn
    for (n = 0; n < 2; n++) begin
      apbWrite(fail_safe_pkg::OFS_CTRL, 32'h00000002);
      refresh();
      apbWrite(fail_safe_pkg::OFS_CTRL, 32'h00000010);
      repeat (4) @(negedge clk);
      checkBit("osc stopped", 1'b0, oscEnable); // stop
      countStep(240, 32'd0); // power-down hold
      @(posedge clk);
      if (n == 0) externalIrqZeroPin <= 1'b0;
      else canReceivePin <= 1'b0;
      repeat (4) @(posedge clk);
      externalIrqZeroPin <= 1'b1;
      canReceivePin <= 1'b1;
      repeat (3) @(negedge clk);
      checkBit("osc restarted", 1'b1, oscEnable); // wake pin
      checkBit("rc clock on wake", 1'b1, clockSelRc); // wake
      waitVector(fail_safe_pkg::VEC_WAKE, 1'b0); // wake vector
      apbRead(fail_safe_pkg::OFS_IRQ_STAT);
      checkWord("no wake flag", 32'h0, lastData); // no flag
    end
    endTest("power_down");
    complete_run();
  end
endmodule
